// ---- reset_and_supply_monitor.sv ----
// Reset and supply monitor: drives the shared active-low reset line and the power states.
// Assumes the startup sequencer reports done/fail and that comparators are asynchronous.
module reset_and_supply_monitor
    import rsm_pkg::*;
#(
    parameter longint MASK_CYC = MASK_CYCLES // External reset mask window, cycles
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Analog comparators (asynchronous)
    input  wire supply_s     supply_raw,
    // Events from the rest of the device
    input  wire logic        on_event,
    input  wire logic        device_reset_req,
    input  wire logic        system_reset_req,
    input  wire logic        sleep_state,
    input  wire logic        startup_done,
    input  wire logic        startup_fail,
    // Reset line, open drain
    input  wire logic        reset_line_in,
    output logic             reset_line_out,
    output logic             reset_line_oe,
    // Status towards the rest of the device
    output logic [2:0]       power_state,
    output logic [1:0]       on_source,
    output logic             registers_restore,
    output logic             supply_low_irq,
    output logic             supply_low_wake,
    output logic             supply_good_pin
);
    // Two-flop synchronisers; stage one is read only by stage two [RULE_24]
    supply_s sup_meta_q, sup_q;
    logic    rl_meta_q, rl_q;
    logic [1:0] own_q;        // Our own pull still in the synchroniser for two edges
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sup_meta_q <= '0;
            sup_q      <= '0;
            rl_meta_q  <= 1'b1;
            rl_q       <= 1'b1;
            own_q      <= 2'b11;
        end else begin
            sup_meta_q <= supply_raw;   // [RULE_24]
            sup_q      <= sup_meta_q;
            rl_meta_q  <= reset_line_in;
            rl_q       <= rl_meta_q;
            own_q      <= {own_q[0], reset_line_oe};
        end
    end

    // Register fields
    logic [2:0] good_thr_q, low_thr_q;
    logic [1:0] low_act_q, dly_q, hold_dur_q;
    logic       soft_dly_q, sleep_mask_q, policy_q, unlocked_q;
    logic       low_prev_q;
    pstate_e    state_q;
    logic [2:0] dev_cnt_q, sw_cnt_q;
    logic       locked_out_q;
    logic [1:0] src_q;
    logic       mask_active_q, stuck_q, mask_expire;
    logic [31:0] mask_cnt_q;
    logic [17:0] tmr_q;

    // Decoded events
    logic soft_wr, ext_low, low_rise, any_start, go_off;
    assign soft_wr  = reg_wr && (reg_addr == SOFT_RESET_ADDR);     // [RULE_11]
    // Line low while we are not driving it and not masked [RULE_10]
    assign ext_low  = !rl_q && !reset_line_oe && !mask_active_q
                      && !(sleep_state && sleep_mask_q) && (own_q == 2'b00);
    assign mask_expire = mask_active_q && !rl_q && (mask_cnt_q == 32'h0000_0000); // [RULE_08]
    assign low_rise = sup_q.low && !low_prev_q;

    // Configuration registers; policy bit needs the key first [RULE_14]
    always_ff @(posedge core_clk) begin
        if (!rst_b || (registers_restore)) begin
            good_thr_q   <= GOOD_THR_RST;   // [RULE_18]
            low_thr_q    <= LOW_THR_RST;    // [RULE_19]
            low_act_q    <= LOW_ACT_RST;
            dly_q        <= DLY_RST;
            soft_dly_q   <= SOFT_DLY_RST;
            hold_dur_q   <= HOLD_DUR_RST;
            sleep_mask_q <= SLEEP_MASK_RST;
            policy_q     <= POLICY_RST;
            unlocked_q   <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                SUPPLY_MON_CTRL_ADDR: begin
                    good_thr_q <= reg_wdata[GOOD_THR_LSB +: 3];  // [RULE_18]
                    low_thr_q  <= reg_wdata[LOW_THR_LSB +: 3];   // [RULE_19]
                    low_act_q  <= reg_wdata[LOW_ACT_LSB +: 2];   // [RULE_20]
                end
                POWER_STATE_ADDR: begin
                    dly_q      <= reg_wdata[DLY_LSB +: 2];
                    soft_dly_q <= reg_wdata[SOFT_DLY_BIT];       // [RULE_12]
                end
                RESET_CTRL_ADDR: begin
                    hold_dur_q   <= reg_wdata[HOLD_DUR_LSB +: 2];
                    sleep_mask_q <= reg_wdata[SLEEP_MASK_BIT];
                    if (unlocked_q) begin
                        policy_q <= reg_wdata[POLICY_BIT];       // [RULE_14]
                    end
                end
                SECURITY_ADDR: begin
                    unlocked_q <= (reg_wdata == USER_KEY);
                end
                default: begin
                end
            endcase
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                SUPPLY_MON_CTRL_ADDR: reg_rdata <= {low_act_q, 2'h0, sup_q.low, 4'h0,
                                                    low_thr_q, 1'b0, good_thr_q}; // [RULE_21]
                POWER_STATE_ADDR: reg_rdata <= {6'h00, soft_dly_q, 7'h00, dly_q};
                RESET_CTRL_ADDR:  reg_rdata <= {5'h00, policy_q, 5'h00, sleep_mask_q,
                                                2'h0, hold_dur_q};
                STATUS_ADDR:      reg_rdata <= {6'h00, locked_out_q, unlocked_q,
                                                dev_cnt_q[1:0], sw_cnt_q[1:0],
                                                1'b0, state_q};
                default:          reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Supply-low edge and responses [RULE_20]
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            low_prev_q      <= 1'b0;
            supply_low_irq  <= 1'b0;
            supply_low_wake <= 1'b0;
        end else begin
            low_prev_q      <= sup_q.low;
            supply_low_irq  <= low_rise;                                // [RULE_20]
            supply_low_wake <= low_rise && (low_act_q == ACT_WAKE);     // [RULE_20]
        end
    end
    assign supply_good_pin = sup_q.good;                               // [RULE_22]

    // Any reason to shut down without restart [RULE_16] [RULE_23]
    assign go_off = sup_q.below_shutdown || system_reset_req
                    || (low_rise && (low_act_q == ACT_OFF));
    assign any_start = on_event && sup_q.good;                          // [RULE_17]

    // Main power-state machine
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_q           <= ST_NO_POWER;
            dev_cnt_q         <= 3'h0;
            sw_cnt_q          <= 3'h0;
            locked_out_q      <= 1'b0;
            src_q             <= SRC_ON_EVENT;
            tmr_q             <= 18'h00000;
            registers_restore <= 1'b0;
            stuck_q           <= 1'b0;
        end else begin
            registers_restore <= 1'b0;
            if (sup_q.por_active) begin
                state_q <= ST_NO_POWER;                                  // [RULE_15]
            end else if (sup_q.backup_active) begin
                state_q <= ST_BACKUP;                                    // [RULE_15]
            end else if (mask_expire) begin
                state_q      <= ST_OFF;                                  // [RULE_08]
                locked_out_q <= 1'b1;
                stuck_q      <= 1'b1;                                    // [RULE_09]
            end else if (go_off && state_q != ST_OFF && state_q != ST_SHUTDOWN) begin
                state_q      <= ST_SHUTDOWN;                             // [RULE_16]
                locked_out_q <= 1'b1;                                    // [RULE_23]
            end else begin
                case (state_q)
                    ST_NO_POWER, ST_BACKUP: state_q <= ST_OFF;
                    ST_OFF: begin
                        // A pending automatic restart or a fresh ON event [RULE_03]
                        if (any_start) begin
                            locked_out_q <= 1'b0;
                            dev_cnt_q    <= 3'h0;
                            sw_cnt_q     <= 3'h0;
                            src_q        <= SRC_ON_EVENT;
                            state_q      <= ST_STARTUP;
                        end else if (!locked_out_q && sup_q.good) begin
                            state_q <= ST_STARTUP;                       // [RULE_01]
                        end
                    end
                    ST_ON: begin
                        if (ext_low) begin
                            src_q             <= SRC_HARDWARE;           // [RULE_06]
                            registers_restore <= 1'b1;
                            state_q           <= ST_SHUTDOWN;
                        end else if (device_reset_req) begin
                            src_q             <= SRC_DEVICE;
                            registers_restore <= 1'b1;
                            dev_cnt_q         <= dev_cnt_q + 3'h1;       // [RULE_02]
                            locked_out_q      <= (dev_cnt_q >= RETRY_MAX); // [RULE_03]
                            state_q           <= ST_SHUTDOWN;
                        end else if (soft_wr) begin
                            src_q        <= SRC_SOFTWARE;                // [RULE_11]
                            sw_cnt_q     <= sw_cnt_q + 3'h1;             // [RULE_02]
                            locked_out_q <= (sw_cnt_q >= RETRY_MAX);     // [RULE_03]
                            tmr_q        <= 18'(DLY_UNIT_CYC) * {16'h0000, dly_q};
                            state_q      <= soft_dly_q ? ST_SOFT_WAIT : ST_SHUTDOWN; // [RULE_12]
                        end
                    end
                    ST_SOFT_WAIT: begin
                        if (tmr_q == 18'h00000) begin
                            state_q <= ST_SHUTDOWN;                      // [RULE_12]
                        end else begin
                            tmr_q <= tmr_q - 18'h00001;
                        end
                    end
                    ST_SHUTDOWN: begin
                        registers_restore <= (src_q == SRC_SOFTWARE) && !policy_q; // [RULE_13]
                        state_q           <= ST_OFF;                     // [RULE_04]
                    end
                    ST_STARTUP: begin
                        // A held line makes the attempt fail unless masked [RULE_09]
                        // The line cannot be watched while we pull it, so a window that
                        // ran out marks the line stuck and fails the next attempt once
                        if (startup_fail || stuck_q) begin
                            stuck_q      <= 1'b0;
                            locked_out_q <= 1'b1;
                            state_q      <= ST_OFF;                      // [RULE_09]
                        end else if (startup_done) begin
                            tmr_q   <= 18'(HOLD_UNIT_CYC) * {16'h0000, hold_dur_q};
                            state_q <= ST_HOLD;                          // [RULE_05]
                        end
                    end
                    ST_HOLD: begin
                        if (tmr_q == 18'h00000) begin
                            state_q <= ST_ON;                            // [RULE_05]
                        end else begin
                            tmr_q <= tmr_q - 18'h00001;
                        end
                    end
                    default: state_q <= ST_OFF;
                endcase
            end
        end
    end

    // Stuck-line mask window after a hardware reset [RULE_07] [RULE_08]
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mask_active_q <= 1'b0;
            mask_cnt_q    <= 32'h0000_0000;
        end else if (state_q == ST_ON && ext_low) begin
            mask_active_q <= 1'b1;                                       // [RULE_07]
            mask_cnt_q    <= 32'(MASK_CYC - 1);
        end else if (mask_active_q) begin
            if (rl_q) begin
                mask_active_q <= 1'b0;                                   // [RULE_07]
            end else if (mask_cnt_q == 32'h0000_0000) begin
                mask_active_q <= 1'b0;                                   // [RULE_08]
            end else begin
                mask_cnt_q <= mask_cnt_q - 32'h0000_0001;
            end
        end
    end

    // Line driven low everywhere except ON and ST_SOFT_WAIT [RULE_04] [RULE_05]
    assign reset_line_out = 1'b0;
    assign reset_line_oe  = (state_q != ST_ON) && (state_q != ST_SOFT_WAIT);
    assign power_state    = state_q;
    assign on_source      = src_q;                                       // [RULE_01]

    // Checks
    chk_line_in_off: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_q == ST_OFF |-> reset_line_oe)
        else $error("reset line not driven in OFF"); // [RULE_04]
    chk_por_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
        sup_q.por_active |=> state_q == ST_NO_POWER)
        else $error("power-on flag did not hold NO POWER"); // [RULE_15]
    chk_no_start_bad: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_q == ST_OFF && locked_out_q && !sup_q.good && !sup_q.por_active
         && !sup_q.backup_active) |=> state_q != ST_STARTUP)
        else $error("start without supply good"); // [RULE_17]
    chk_soft_nodelay: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_q == ST_ON && soft_wr && !soft_dly_q && !ext_low && !device_reset_req
         && !go_off && !sup_q.por_active && !sup_q.backup_active)
        |=> state_q == ST_SHUTDOWN)
        else $error("soft reset did not start shutdown"); // [RULE_11]
    chk_low_status: assert property (@(posedge core_clk) disable iff (!rst_b)
        reg_rd && reg_addr == SUPPLY_MON_CTRL_ADDR |=> reg_rdata[LOW_STS_BIT] == $past(sup_q.low))
        else $error("low status mismatch"); // [RULE_21]
    chk_key_lock: assert property (@(posedge core_clk) disable iff (!rst_b)
        (reg_wr && reg_addr == RESET_CTRL_ADDR && !unlocked_q && !registers_restore)
        |=> $stable(policy_q))
        else $error("policy changed while locked"); // [RULE_14]
    chk_shut_off: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sup_q.below_shutdown && !sup_q.por_active && !sup_q.backup_active
         && state_q != ST_OFF && state_q != ST_SHUTDOWN && !mask_expire) |=> state_q == ST_SHUTDOWN)
        else $error("shutdown level ignored"); // [RULE_16]
    chk_good_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
        supply_good_pin == sup_q.good)
        else $error("good pin mismatch"); // [RULE_22]
    cov_soft_reset: cover property (@(posedge core_clk) state_q == ST_SOFT_WAIT);
    cov_hw_mask:    cover property (@(posedge core_clk) mask_active_q);
    cov_lockout:    cover property (@(posedge core_clk) locked_out_q && state_q == ST_OFF);
endmodule

// ---- reset_line_partner.sv ----
// External reset source that shares the active-low reset line.
// Assumes a pull-up on the wire; the device pulls low through its enable.
module reset_line_partner (
    // Clock
    input  wire logic        core_clk,
    // Commands from the bench
    input  wire logic        go,
    input  wire logic [15:0] len,
    // Device side of the wire
    input  wire logic        dev_oe,
    input  wire logic        dev_out,
    // Resolved wire level
    output logic             line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left_q = 16'h0; // Cycles of pull still to go

    // Pull low for len cycles, then release to the pull-up
    always_ff @(posedge core_clk) begin
        if (go) begin
            left_q <= len;
        end else if (left_q != 16'h0) begin
            left_q <= left_q - 16'h1;
        end
    end
    // Low wins: either party pulling low sets the wire low
    assign line = !((dev_oe && !dev_out) || (left_q != 16'h0));
endmodule

// ---- rsm_pkg.sv ----
// Package for the reset and supply monitor: register map, fields, resets, timing.
// Assumes a 40 MHz always-on clock and a plain register port with 16-bit data.
// Notes on behaviour
// [RULE_01] Auto-recovering resets restart ON, record cause
// [RULE_02] At most six device or software restarts
// [RULE_03] Past limit, stay OFF until ON event
// [RULE_04] Reset line low from shutdown through OFF
// [RULE_05] Release line after startup plus hold duration
// [RULE_06] External low: OFF, defaults, then schedule ON
// [RULE_07] Mask stuck external reset up to 32 s
// [RULE_08] Still low at expiry: force OFF
// [RULE_09] ON event during held reset fails back OFF
// [RULE_10] Sleep mask bit ignores reset line in SLEEP
// [RULE_11] Any write to 0000h is software reset
// [RULE_12] Delay bit waits power-state delay before shutdown
// [RULE_13] Policy bit chooses register restore on soft reset
// [RULE_14] Policy bit writable only after user key
// [RULE_15] Hold NO POWER and BACKUP on supply flags
// [RULE_16] Shutdown comparator forces OFF
// [RULE_17] Block ON requests without supply good
// [RULE_18] Supply-good threshold field bits 2:0, default 101
// [RULE_19] Supply-low threshold field bits 6:4, default 010
// [RULE_20] Supply-low action field selects response
// [RULE_21] Supply-low status bit 11 follows flag
// [RULE_22] Supply-good pin output follows supply good
// [RULE_23] System resets: OFF, line low, no restart
// [RULE_24] Synchronise comparators and reset line input
package rsm_pkg;
    // Register offsets (word addresses on the register port)
    localparam logic [15:0] SOFT_RESET_ADDR      = 16'h0000;
    localparam logic [15:0] SUPPLY_MON_CTRL_ADDR = 16'h4001;
    localparam logic [15:0] POWER_STATE_ADDR     = 16'h4003;
    localparam logic [15:0] RESET_CTRL_ADDR      = 16'h4006;
    localparam logic [15:0] SECURITY_ADDR        = 16'h4008;
    localparam logic [15:0] STATUS_ADDR          = 16'h4009;
    // Field positions
    localparam int GOOD_THR_LSB      = 0;
    localparam int LOW_THR_LSB       = 4;
    localparam int LOW_STS_BIT       = 11;
    localparam int LOW_ACT_LSB       = 14;
    localparam int DLY_LSB           = 0;
    localparam int SOFT_DLY_BIT      = 9;
    localparam int HOLD_DUR_LSB      = 0;
    localparam int SLEEP_MASK_BIT    = 4;
    localparam int POLICY_BIT        = 10;
    // Reset values
    localparam logic [2:0] GOOD_THR_RST  = 3'h5;
    localparam logic [2:0] LOW_THR_RST   = 3'h2;
    localparam logic [1:0] LOW_ACT_RST   = 2'h0;
    localparam logic [1:0] DLY_RST       = 2'h0;
    localparam logic       SOFT_DLY_RST  = 1'b0;
    localparam logic [1:0] HOLD_DUR_RST  = 2'h0;
    localparam logic       SLEEP_MASK_RST = 1'b0;
    localparam logic       POLICY_RST    = 1'b1;
    // User key code (arbitrary value)
    localparam logic [15:0] USER_KEY     = 16'h9716;
    // Supply-low action encodings
    localparam logic [1:0] ACT_IRQ  = 2'h0;
    localparam logic [1:0] ACT_WAKE = 2'h1;
    localparam logic [1:0] ACT_OFF  = 2'h3;
    // Retry limit
    localparam logic [2:0] RETRY_MAX = 3'h6;
    // Timing
    localparam int CLK_HZ          = 40_000_000;
    localparam int MASK_TIME_S     = 32;
    localparam longint MASK_CYCLES = longint'(MASK_TIME_S) * CLK_HZ;
    localparam int HOLD_UNIT_MS    = 1;
    localparam int HOLD_UNIT_CYC   = HOLD_UNIT_MS * (CLK_HZ / 1000);
    localparam int DLY_UNIT_MS     = 1;
    localparam int DLY_UNIT_CYC    = DLY_UNIT_MS * (CLK_HZ / 1000);
    // Power states
    typedef enum logic [2:0] {
        ST_NO_POWER, ST_BACKUP, ST_OFF, ST_SOFT_WAIT, ST_SHUTDOWN,
        ST_STARTUP, ST_HOLD, ST_ON
    } pstate_e;
    // Reset cause codes recorded as on-source
    typedef enum logic [1:0] {
        SRC_ON_EVENT, SRC_DEVICE, SRC_HARDWARE, SRC_SOFTWARE
    } src_e;
    // Digitised comparator and system inputs
    typedef struct packed {
        logic por_active;       // Power-on reset flag
        logic backup_active;    // Internal supply reset flag
        logic below_shutdown;   // Main supply under shutdown level
        logic good;             // Supply good flag
        logic low;              // Supply low flag
    } supply_s;
endpackage

// ---- tb.sv ----
// Self-checking bench for the reset and supply monitor.
// Assumes the mask window is shortened to 200 cycles and a zero hold duration.
module tb;
    import rsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {bit wr; logic [15:0] a; logic [15:0] d;} row_t;
    logic core_clk, rst_b, reg_wr, reg_rd, on_event, done, fail, sysr, go, line, oe, out, rest;
    logic low_irq, low_wake, good_pin;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, len;
    supply_s     supply_raw;
    logic [2:0]  power_state;
    logic [1:0]  on_source;
    int n_fail = 0, check_count = 0, irq_n = 0;
    // Register rows: reads with their expected data, mixed with writes
    row_t rows[12] = '{
        '{0, RESET_CTRL_ADDR, 16'h0400}, '{0, SUPPLY_MON_CTRL_ADDR, 16'h0025},
        '{0, POWER_STATE_ADDR, 16'h0000}, '{0, 16'h1234, 16'h0000},
        '{1, POWER_STATE_ADDR, 16'h0001}, '{0, POWER_STATE_ADDR, 16'h0001},
        '{1, RESET_CTRL_ADDR, 16'h0000}, '{0, RESET_CTRL_ADDR, 16'h0400},
        '{1, SECURITY_ADDR, USER_KEY}, '{1, RESET_CTRL_ADDR, 16'h0000},
        '{0, RESET_CTRL_ADDR, 16'h0000}, '{1, SUPPLY_MON_CTRL_ADDR, 16'h0825}};

    reset_and_supply_monitor #(.MASK_CYC(200)) reset_and_supply_monitor_i (.core_clk(core_clk),
        .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_raw(supply_raw), .on_event(on_event),
        .device_reset_req(1'b0), .system_reset_req(sysr), .sleep_state(1'b0),
        .startup_done(done), .startup_fail(fail), .reset_line_in(line), .reset_line_out(out),
        .reset_line_oe(oe), .power_state(power_state), .on_source(on_source),
        .registers_restore(rest), .supply_low_irq(low_irq), .supply_low_wake(low_wake),
        .supply_good_pin(good_pin));
    reset_line_partner reset_line_partner_i (.core_clk(core_clk), .go(go), .len(len),
        .dev_oe(oe), .dev_out(out), .line(line));

    // Free-running 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Count interrupt pulses; a level would be counted many times
    always @(posedge core_clk) if (low_irq === 1'b1) irq_n++;

    // Compare and report
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read: data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask
    // Bounded wait for a power state, then compare it
    task automatic wait_st(input pstate_e st, input int n);
        int k;
        k = 0;
        while (power_state !== st && k < n) begin
            @(posedge core_clk); #1 k++;
        end
        chk("power_state", {13'h0, power_state}, {13'h0, st});
    endtask
    // Single-cycle pulse on a chosen event input; 3 pulses both fail and system reset
    task automatic pulse(input int w);
        @(posedge core_clk);
        if (w == 0) on_event <= 1'b1; else if (w == 1) done <= 1'b1; else sysr <= 1'b1;
        if (w == 3) fail <= 1'b1;
        @(posedge core_clk);
        {on_event, done, sysr, fail} <= 4'h0;
    endtask
    // Optional ON request, then startup completes and the line is released
    task automatic boot(input bit ev);
        if (ev) pulse(0);
        wait_st(ST_STARTUP, 300);
        chk("oe_startup", oe, 1'b1);
        pulse(1);
        wait_st(ST_ON, 50);
        chk("oe_on", oe, 1'b0);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog at 20000 cycles, well above the under a thousand cycles the tests take
    initial begin
        #(25 * 20000);
        n_fail++;
        print_verdict();
    end

    initial begin
        {rst_b, reg_wr, reg_rd, on_event, done, fail, sysr, go} = 8'h0;
        {reg_addr, reg_wdata, len} = '0;
        supply_raw = '{por_active: 1'b1, backup_active: 1'b0, below_shutdown: 1'b0,
                       good: 1'b1, low: 1'b0};
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        // Register rows: defaults, unmapped, key lock, read-only status
        foreach (rows[i]) if (rows[i].wr) wr(rows[i].a, rows[i].d); else rd(rows[i].a, rows[i].d);
        rd(SUPPLY_MON_CTRL_ADDR, 16'h0025);
        $display("test registers done");
        wait_st(ST_NO_POWER, 5);
        supply_raw.por_active <= 1'b0;
        wait_st(ST_OFF, 20);
        boot(1);
        chk("on_source", on_source, SRC_ON_EVENT);
        // Seven soft resets: six restart, the seventh stays off
        for (int i = 0; i < 7; i++) begin
            wr(SOFT_RESET_ADDR, 16'h5A5A);
            if (i < 6) begin
                boot(0);
                chk("on_source", on_source, SRC_SOFTWARE);
            end else begin
                repeat (30) @(posedge core_clk);
                wait_st(ST_OFF, 1);
                chk("oe_off", oe, 1'b1);
            end
            if (i == 0) rd(POWER_STATE_ADDR, 16'h0000);
        end
        boot(1);
        $display("test soft reset done");
        // Short external pull: off, then back on
        len <= 16'd20; go <= 1'b1;
        @(posedge core_clk) go <= 1'b0;
        wait_st(ST_OFF, 10);
        repeat (30) @(posedge core_clk);
        boot(0);
        chk("on_source", on_source, SRC_HARDWARE);
        // Stuck pull outlasts the mask window
        len <= 16'd400; go <= 1'b1;
        @(posedge core_clk) go <= 1'b0;
        repeat (260) @(posedge core_clk);
        wait_st(ST_OFF, 1);
        pulse(0);
        repeat (10) @(posedge core_clk);
        pulse(3);
        wait_st(ST_OFF, 20);
        repeat (150) @(posedge core_clk);
        boot(1);
        $display("test hardware reset done");
        // System reset: off, line low, no restart
        pulse(2);
        repeat (20) @(posedge core_clk);
        wait_st(ST_OFF, 1);
        chk("oe_sys", oe, 1'b1);
        supply_raw.good <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk("good_pin", good_pin, 1'b0);
        pulse(0);
        repeat (20) @(posedge core_clk);
        wait_st(ST_OFF, 1);
        supply_raw.good <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("good_pin", good_pin, 1'b1);
        // Supply low with default action raises one interrupt pulse
        supply_raw.low <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(SUPPLY_MON_CTRL_ADDR, 16'h0825);
        chk("irq_count", irq_n[15:0], 16'h1);
        supply_raw.low <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(SUPPLY_MON_CTRL_ADDR, 16'h0025);
        boot(1);
        supply_raw.below_shutdown <= 1'b1;
        wait_st(ST_OFF, 10);
        $display("test supply done");
        print_verdict();
    end
endmodule
